// [logic/ht_timer_ctrl.v]
/*
 * High-half timer control slice: control word, global mode, high counter and
 * period behind an AXI4-Lite slave, plus the counting state machine.
 * Assumes a single 125 MHz aclk; low-timer logic lives elsewhere and reports
 * its output level on low_timer_status from the same clock domain.
 */
// The AXI4-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "ht_map.vh"

module ht_timer_ctrl (
  input wire aclk, // system clock
  input wire aresetn, // synchronous reset, active low
  input wire [`HT_ADDR_W-1:0] s_axi_awaddr, // write address
  input wire [2:0] s_axi_awprot, // write protection, unused
  input wire s_axi_awvalid, // write address valid
  output wire s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write byte strobes
  input wire s_axi_wvalid, // write data valid
  output wire s_axi_wready, // write data ready
  output wire [1:0] s_axi_bresp, // write response
  output wire s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [`HT_ADDR_W-1:0] s_axi_araddr, // read address
  input wire [2:0] s_axi_arprot, // read protection, unused
  input wire s_axi_arvalid, // read address valid
  output wire s_axi_arready, // read address ready
  output wire [31:0] s_axi_rdata, // read data
  output wire [1:0] s_axi_rresp, // read response
  output wire s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  input wire low_timer_status, // low timer output level
  output wire [15:0] low_timer_ctrl, // low-half control fields to low timer
  output wire [1:0] global_timer_mode, // global timer mode
  output wire high_timer_out, // high timer output pin level
  output wire [31:0] high_timer_count // high counter value
);

  // idle waits for an enable, done parks a finished one-shot
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_DONE = 2'h2;

  // registers
  reg [31:0] ctrl_reg;
  reg [31:0] gctrl_reg;
  reg [31:0] cnt_reg;
  reg [31:0] prd_reg;
  reg [1:0] state_reg;
  reg reach_reg;
  reg [7:0] div_reg;
  reg tick_reg;
  reg out_reg;

  // bus registers
  reg aw_held_reg;
  reg [`HT_ADDR_W-1:0] awaddr_reg;
  reg w_held_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  reg rvalid_reg;
  reg [1:0] rresp_reg;
  reg [31:0] rdata_reg;

  // write path, read handshake and output control wires
  wire aw_hs;
  wire w_hs;
  wire wr_fire;
  wire [`HT_ADDR_W-1:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire [31:0] strb_mask;
  wire wr_ctrl;
  wire wr_gctrl;
  wire wr_cnt;
  wire wr_prd;
  wire wr_hit;
  wire ar_hs;
  wire shaped;
  wire dual_mode;
  wire out_invert;

  // field views
  wire [1:0] gmode;
  wire [1:0] en_mode;
  wire run_ok;
  wire clock_mode;
  wire [31:0] cnt_inc;

  reg [31:0] rd_word;
  reg rd_hit;

  // write address and data may arrive in either order; each is held alone
  // a response still waiting for bready blocks both channels: one write at a time
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign wr_fire = (aw_held_reg || aw_hs) && (w_held_reg || w_hs) && !bvalid_reg;
  assign wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
  assign wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
  assign wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;

  // byte strobes widen to a bit mask so every register honours partial writes
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_strb
      assign strb_mask[gi*8+7:gi*8] = {8{wr_strb[gi]}};
    end
  endgenerate

  assign wr_ctrl = wr_fire && (wr_addr == `HT_OFF_CTRL);
  assign wr_gctrl = wr_fire && (wr_addr == `HT_OFF_GCTRL);
  assign wr_cnt = wr_fire && (wr_addr == `HT_OFF_CNT);
  assign wr_prd = wr_fire && (wr_addr == `HT_OFF_PRD);
  assign wr_hit = wr_ctrl || wr_gctrl || wr_cnt || wr_prd;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= {`HT_ADDR_W{1'b0}};
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `HT_RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? `HT_RESP_OKAY : `HT_RESP_SLVERR;
      end else begin
        if (aw_hs) begin
          aw_held_reg <= 1'b1;
          awaddr_reg <= s_axi_awaddr;
        end
        if (w_hs) begin
          w_held_reg <= 1'b1;
          wdata_reg <= s_axi_wdata;
          wstrb_reg <= s_axi_wstrb;
        end
        if (bvalid_reg && s_axi_bready) begin
          bvalid_reg <= 1'b0;
        end
      end
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // control and configuration registers; reserved bits never store
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `HT_CTRL_RST;
      gctrl_reg <= `HT_GCTRL_RST;
      prd_reg <= `HT_PRD_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= (ctrl_reg & ~(strb_mask & `HT_CTRL_WMASK))
                  | (wr_data & strb_mask & `HT_CTRL_WMASK);
      end
      if (wr_gctrl) begin
        gctrl_reg <= (gctrl_reg & ~(strb_mask & `HT_GCTRL_WMASK))
                   | (wr_data & strb_mask & `HT_GCTRL_WMASK);
      end
      if (wr_prd) begin
        prd_reg <= (prd_reg & ~strb_mask) | (wr_data & strb_mask);
      end
    end
  end

  assign gmode = gctrl_reg[`HT_GMODE_MSB:`HT_GMODE_LSB];
  assign en_mode = ctrl_reg[`HT_EN_MSB:`HT_EN_LSB];
  // outside dual unchained mode the high fields are inert, output shaping too
  assign dual_mode = (gmode == `HT_GMODE_DUAL_UNCH);
  // reserved enable code 11b is treated like disabled
  assign run_ok = dual_mode
                  && ((en_mode == `HT_EN_ONCE) || (en_mode == `HT_EN_CONT));
  // watchdog forces pulse mode on its own, should the dual gate ever be widened
  assign clock_mode = dual_mode && ctrl_reg[`HT_CP_BIT]
                      && (gmode != `HT_GMODE_WDOG);
  assign out_invert = dual_mode && ctrl_reg[`HT_INV_BIT];
  assign cnt_inc = cnt_reg + 32'h0000_0001;

  // timer clock enable derived from aclk
  // with a divide count of 1 the enable is high on every cycle after reset
  always @(posedge aclk) begin
    if (!aresetn) begin
      div_reg <= 8'h00;
      tick_reg <= 1'b0;
    end else if (div_reg >= `HT_TICK_DIV - 8'h01) begin
      div_reg <= 8'h00;
      tick_reg <= 1'b1;
    end else begin
      div_reg <= div_reg + 8'h01;
      tick_reg <= 1'b0;
    end
  end

  // high counter state machine; a software write to the counter wins
  // reach is raised with the final increment, so the shaper starts one cycle
  // later while the counter still shows the period
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      cnt_reg <= `HT_CNT_RST;
      reach_reg <= 1'b0;
    end else begin
      reach_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (run_ok) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!run_ok) begin
            state_reg <= ST_IDLE; // count holds
          end else if (tick_reg) begin
            if (cnt_reg == prd_reg) begin
              if (en_mode == `HT_EN_CONT) begin
                cnt_reg <= 32'h0000_0000; // reload one tick after reaching
              end else begin
                state_reg <= ST_DONE;
              end
            end else begin
              cnt_reg <= cnt_inc;
              if (cnt_inc == prd_reg) begin
                reach_reg <= 1'b1;
                if (en_mode == `HT_EN_ONCE) begin
                  state_reg <= ST_DONE;
                end
              end
            end
          end
        end
        ST_DONE: begin
          // a fresh control write re-arms the one-shot
          if (!run_ok || wr_ctrl) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
      if (wr_cnt) begin
        cnt_reg <= (cnt_reg & ~strb_mask) | (wr_data & strb_mask);
      end
    end
  end

  ht_out_shaper i_ht_out_shaper (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick_reg),
    .reach(reach_reg),
    .clock_mode(clock_mode),
    .pwid(ctrl_reg[`HT_PWID_MSB:`HT_PWID_LSB]),
    .invert(out_invert),
    .level(shaped)
  );

  // output level registered so pin and status bit agree to the cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      out_reg <= 1'b0;
    end else begin
      out_reg <= shaped;
    end
  end

  assign high_timer_out = out_reg;
  assign high_timer_count = cnt_reg;
  assign global_timer_mode = gmode;
  // bit 0 of the low half is status; the low timer never sees it as a control
  assign low_timer_ctrl = {ctrl_reg[15:1], 1'b0};

  // read path
  // data is captured at the address handshake, so a write landing while
  // rvalid waits cannot change a word already on its way back
  assign s_axi_arready = !rvalid_reg;
  assign ar_hs = s_axi_arvalid && s_axi_arready;

  always @* begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `HT_OFF_CTRL: begin
        rd_word = ctrl_reg & `HT_CTRL_WMASK;
        rd_word[`HT_STAT_BIT] = out_reg;
        rd_word[`HT_LOW_STAT_BIT] = low_timer_status;
      end
      `HT_OFF_GCTRL: begin
        rd_word = gctrl_reg & `HT_GCTRL_WMASK;
      end
      `HT_OFF_CNT: begin
        rd_word = cnt_reg;
      end
      `HT_OFF_PRD: begin
        rd_word = prd_reg;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= `HT_RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end else if (ar_hs) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= rd_hit ? `HT_RESP_OKAY : `HT_RESP_SLVERR;
      rdata_reg <= rd_word;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

endmodule

// [logic/ht_map.vh]
/*
 * Register map, field positions, reset values, encodings and timing counts
 * for the high-half timer control block.
 * Assumes inclusion by bare name from the design files; definitions only.
 */
`ifndef HT_MAP_VH
`define HT_MAP_VH

// register byte offsets on the AXI4-Lite port
`define HT_ADDR_W 8
`define HT_OFF_CTRL 8'h00
`define HT_OFF_GCTRL 8'h04
`define HT_OFF_CNT 8'h08
`define HT_OFF_PRD 8'h0C

// control word fields
`define HT_EN_MSB 23
`define HT_EN_LSB 22
`define HT_PWID_MSB 21
`define HT_PWID_LSB 20
`define HT_CP_BIT 19
`define HT_INV_BIT 17
`define HT_STAT_BIT 16
`define HT_LOW_STAT_BIT 0
`define HT_CTRL_WMASK 32'h00FA_03FE
`define HT_CTRL_RST 32'h0000_0000

// global control word: global timer mode in bits 3:2
`define HT_GMODE_MSB 3
`define HT_GMODE_LSB 2
`define HT_GCTRL_WMASK 32'h0000_000C
`define HT_GCTRL_RST 32'h0000_0000
`define HT_CNT_RST 32'h0000_0000
`define HT_PRD_RST 32'h0000_0000

// encodings
`define HT_GMODE_DUAL_UNCH 2'h1
`define HT_GMODE_WDOG 2'h2
`define HT_EN_OFF 2'h0
`define HT_EN_ONCE 2'h1
`define HT_EN_CONT 2'h2

// bus responses
`define HT_RESP_OKAY 2'h0
`define HT_RESP_SLVERR 2'h2

// timer clock = aclk divided by this count (1 = every aclk cycle)
`define HT_TICK_DIV 8'h01

`endif

// [logic/ht_out_shaper.v]
/*
 * Output shaper for the high timer: pulse of 1..4 timer clocks or 50% toggle,
 * with optional inversion.
 * Assumes tick and reach are one-cycle pulses on aclk; reach comes in the
 * cycle after the tick that made the counter reach its period.
 */
`timescale 1ns/1ps
module ht_out_shaper (
  input wire aclk, // system clock
  input wire aresetn, // synchronous reset, active low
  input wire tick, // timer clock enable pulse
  input wire reach, // counter reached period, one-cycle pulse
  input wire clock_mode, // 1 toggles, 0 pulses
  input wire [1:0] pwid, // pulse width code
  input wire invert, // invert output
  output wire level // shaped output level
);

  reg raw_reg;
  reg [1:0] rem_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      raw_reg <= 1'b0;
      rem_reg <= 2'h0;
    end else if (reach) begin
      if (clock_mode) begin
        raw_reg <= ~raw_reg;
        rem_reg <= 2'h0;
      end else begin
        raw_reg <= 1'b1;
        rem_reg <= pwid; // width is pwid+1 timer clocks
      end
    end else if (tick && !clock_mode && raw_reg) begin
      if (rem_reg == 2'h0) begin
        raw_reg <= 1'b0;
      end else begin
        rem_reg <= rem_reg - 2'h1;
      end
    end
  end

  // inversion is applied after the shaper so a flip takes effect at once
  assign level = raw_reg ^ invert;

endmodule

// [verif/ht_timer_ctrl_monitor.sv]
/* bus and counter checks for ht_timer_ctrl
   assumes a single aclk domain and binding onto the design top */
`timescale 1ns/1ps
`include "ht_map.vh"
module ht_timer_ctrl_monitor (
  input wire aclk, // clock
  input wire aresetn, // reset, active low
  input wire s_axi_awvalid, // aw valid
  input wire s_axi_awready, // aw ready
  input wire s_axi_wvalid, // w valid
  input wire s_axi_wready, // w ready
  input wire [1:0] s_axi_bresp, // b response
  input wire s_axi_bvalid, // b valid
  input wire s_axi_bready, // b ready
  input wire [`HT_ADDR_W-1:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // ar valid
  input wire s_axi_arready, // ar ready
  input wire [31:0] s_axi_rdata, // read data
  input wire [1:0] s_axi_rresp, // r response
  input wire s_axi_rvalid, // r valid
  input wire s_axi_rready, // r ready
  input wire [15:0] low_timer_ctrl, // low half fields
  input wire [1:0] global_timer_mode, // global mode
  input wire [31:0] high_timer_count // high counter
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence b_ack;
    s_axi_bvalid && s_axi_bready;
  endsequence
  sequence ctrl_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `HT_OFF_CTRL;
  endsequence
  // writes in flight may legally move the counter, so they are excluded
  sequence no_write;
    !s_axi_awvalid && !s_axi_wvalid;
  endsequence
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped early");
  resp_clear_a: assert property (b_ack |=> !s_axi_bvalid) else $error("bvalid kept");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar open");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("aw or w open during response");
  count_hold_a: assert property (global_timer_mode != 2'h1 and no_write |=>
    $stable(high_timer_count)) else $error("count moved outside dual mode");
  count_step_a: assert property (no_write |=> high_timer_count == 32'h0000_0000 ||
    high_timer_count == $past(high_timer_count) + 32'h0000_0001 ||
    $stable(high_timer_count)) else $error("count jumped");
  reserved_zero_a: assert property (ctrl_read |=> s_axi_rdata[31:24] == 8'h00 &&
    !s_axi_rdata[18]) else $error("reserved bits read nonzero");
  low_stat_a: assert property (no_write |=> low_timer_ctrl[0] == 1'h0 &&
    $stable(low_timer_ctrl)) else $error("low ctrl changed without a write");
endmodule
bind ht_timer_ctrl ht_timer_ctrl_monitor i_ht_timer_ctrl_monitor (.*);

// [verif/ht_timer_ctrl_tb.sv]
/* register-level testbench for ht_timer_ctrl
   assumes an AXI4-Lite slave with a timer tick every aclk */
`timescale 1ns/1ps
module ht_timer_ctrl_tb;
  reg aclk = 1'h0;
  reg aresetn = 1'h0;
  reg [7:0] awaddr = 8'h00;
  reg [7:0] araddr = 8'h00;
  reg [31:0] wdata = 32'h0000_0000;
  reg awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  reg lts = 1'h0;
  reg [1:0] rs;
  reg [31:0] rd;
  wire awready, wready, bvalid, arready, rvalid, hout;
  wire [1:0] bresp, rresp, gm;
  wire [31:0] rdata, cnt;
  wire [15:0] lctl;
  integer errors = 0, num_checks = 0, cyc = 0, n, i;
  always #4 aclk = ~aclk;
  ht_timer_ctrl i_ht_timer_ctrl (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .low_timer_status(lts),
    .low_timer_ctrl(lctl), .global_timer_mode(gm), .high_timer_out(hout),
    .high_timer_count(cnt));
  task complete_run;
    begin
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  task check32(input string nm, input [31:0] e, input [31:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("Error %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    reg done;
    begin
      done = 1'h0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (!done) begin
        @(posedge aclk);
        if (awvalid && awready === 1'h1) awvalid <= 1'h0;
        if (wvalid && wready === 1'h1) wvalid <= 1'h0;
        if (bready && bvalid === 1'h1) begin
          done = 1'h1;
          rs = bresp;
        end
      end
      bready <= 1'h0;
      check32("bresp", {30'h0, er}, {30'h0, rs});
    end
  endtask
  task rdr(input [7:0] a, input [31:0] e, input [1:0] er);
    reg done;
    begin
      done = 1'h0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      while (!done) begin
        @(posedge aclk);
        if (arvalid && arready === 1'h1) arvalid <= 1'h0;
        if (rready && rvalid === 1'h1) begin
          done = 1'h1;
          rs = rresp;
          rd = rdata;
        end
      end
      rready <= 1'h0;
      check32("rresp", {30'h0, er}, {30'h0, rs});
      check32("rdata", e, rd);
    end
  endtask
  // length of the next complete run of the output at level lvl, in aclk cycles
  // after a short settle, so a pulse launched under the old control word is skipped
  task run_len(input lvl);
    begin
      repeat (10) @(posedge aclk);
      while (hout === lvl) @(posedge aclk);
      while (hout !== lvl) @(posedge aclk);
      n = 0;
      while (hout === lvl) begin
        n = n + 1;
        @(posedge aclk);
      end
    end
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors = errors + 1;
      complete_run;
    end
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    for (i = 0; i < 4; i = i + 1) rdr(i[5:0] * 8'h04, 32'h0000_0000, 2'h0);
    lts <= 1'h1;
    wr(8'h00, 32'hFFFF_FFFF, 2'h0);
    rdr(8'h00, 32'h00FA_03FF, 2'h0);
    check32("low ctrl", 32'h0000_03FE, {16'h0000, lctl});
    check32("invert outside dual", 32'h0000_0000, {31'h0, hout});
    wr(8'h10, 32'h0000_1234, 2'h2);
    rdr(8'h10, 32'h0000_0000, 2'h2);
    wr(8'h0c, 32'h0000_0004, 2'h0);
    wr(8'h08, 32'h0000_0000, 2'h0);
    wr(8'h00, 32'h0080_0000, 2'h0);
    repeat (8) @(posedge aclk);
    check32("count no dual", 32'h0000_0000, cnt);
    wr(8'h04, 32'h0000_0004, 2'h0);
    check32("global mode", 32'h0000_0001, {30'h0, gm});
    while (cnt !== 32'h0000_0004) @(posedge aclk);
    @(posedge aclk);
    check32("reload", 32'h0000_0000, cnt);
    // period 4 gives a 5-tick cycle, so every width fits between pulses
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h00, 32'h0080_0000 | (i << 20), 2'h0);
      run_len(1'h1);
      check32("pulse width", i + 1, n);
    end
    wr(8'h00, 32'h0092_0000, 2'h0);
    run_len(1'h0);
    check32("inverted width", 32'h0000_0002, n);
    wr(8'h00, 32'h00B8_0000, 2'h0);
    run_len(1'h1);
    check32("clock high", 32'h0000_0005, n);
    run_len(1'h0);
    check32("clock low", 32'h0000_0005, n);
    wr(8'h0c, 32'h0000_0014, 2'h0);
    run_len(1'h0);
    check32("clock low long", 32'h0000_0015, n);
    // the output has just gone high; watchdog must force pulse mode and drop it
    wr(8'h04, 32'h0000_0008, 2'h0);
    check32("global mode", 32'h0000_0002, {30'h0, gm});
    repeat (4) @(posedge aclk);
    check32("watchdog pulse", 32'h0000_0000, {31'h0, hout});
    wr(8'h0c, 32'h0000_0004, 2'h0);
    wr(8'h04, 32'h0000_0004, 2'h0);
    wr(8'h00, 32'h0002_0000, 2'h0);
    repeat (10) @(posedge aclk);
    check32("idle inverted", 32'h0000_0001, {31'h0, hout});
    rdr(8'h00, 32'h0003_0001, 2'h0);
    wr(8'h08, 32'h0000_0000, 2'h0);
    wr(8'h00, 32'h0040_0000, 2'h0);
    repeat (20) @(posedge aclk);
    check32("one shot", 32'h0000_0004, cnt);
    wr(8'h08, 32'h0000_0001, 2'h0);
    wr(8'h00, 32'h00C0_0000, 2'h0);
    repeat (8) @(posedge aclk);
    check32("hold", 32'h0000_0001, cnt);
    rdr(8'h00, 32'h00C0_0001, 2'h0);
    complete_run;
  end
endmodule
